// ===== design/bmr_pkg.sv
/*
  Package for the battery monitor register block: byte addresses of the
  register page, status bit positions, command codes and timing counts.
  Assumes a 10 MHz system clock.
*/
package bmr_pkg;
  // byte addresses
  localparam logic [7:0] TEMP_LO_ADDR = 8'h60;
  localparam logic [7:0] TEMP_HI_ADDR = 8'h61;
  localparam logic [7:0] STAT_LO_ADDR = 8'h62;
  localparam logic [7:0] STAT_HI_ADDR = 8'h63;
  localparam logic [7:0] VOLT_LO_ADDR = 8'h77;
  localparam logic [7:0] VOLT_HI_ADDR = 8'h78;
  localparam logic [7:0] MAKER_LO_ADDR = 8'h80;
  localparam logic [7:0] MAKER_HI_ADDR = 8'h81;
  localparam logic [7:0] CYCLE_LO_ADDR = 8'h82;
  localparam logic [7:0] CYCLE_HI_ADDR = 8'h83;
  // status bit positions
  localparam int STAT_TEMP_BIT = 0;
  localparam int STAT_NV_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_VOLT_BIT = 3;
  localparam logic [7:0] STAT_HI_VALUE = 8'hff;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  // commands
  localparam logic [7:0] CMD_CONVERT_VOLT = 8'hb4;
  localparam int FUNC_CMD_COUNT = 15;
  // check value
  localparam logic [7:0] CRC_POLY_REFLECT = 8'h8c;
  localparam logic [7:0] CRC_RESET = 8'h00;
  // widths and reset values
  localparam int TEMP_BITS = 13;
  localparam int VOLT_BITS = 10;
  localparam logic [15:0] CYCLE_MAX = 16'hffff;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int VOLT_CONV_MS = 10;
  localparam int NV_COPY_MIN_MS = 2;
  localparam int NV_COPY_MAX_MS = 10;
  localparam int VOLT_CONV_CYCLES = CLK_HZ / 1000 * VOLT_CONV_MS;
  localparam int NV_COPY_MIN_CYCLES = CLK_HZ / 1000 * NV_COPY_MIN_MS;
  localparam int NV_COPY_MAX_CYCLES = CLK_HZ / 1000 * NV_COPY_MAX_MS;
  typedef enum {ST_IDLE, ST_BUSY} bmr_conv_type;
endpackage

// ===== design/bmr_crc8.sv
/*
  Serial 8-bit check value generator, reflected form of x^8+x^5+x^4+1.
  Assumes the caller feeds one bit per clock, least significant bit first.
*/
`timescale 1ns/1ps
module bmr_crc8 (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic shift_in,
  input wire logic bit_in,
  output logic [7:0] crc_out
);
  logic [7:0] crc_q;
  logic [7:0] crc_d;
  logic fb;

  // next value: clear to zero, else shift one bit in
  always_comb begin
    fb = crc_q[0] ^ bit_in;
    crc_d = crc_q;
    if (clear_in) begin
      crc_d = bmr_pkg::CRC_RESET;
    end else if (shift_in) begin
      crc_d = {1'b0, crc_q[7:1]} ^ (fb ? bmr_pkg::CRC_POLY_REFLECT : 8'h00);
    end
  end

  // register the check value
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      crc_q <= bmr_pkg::CRC_RESET;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc_out = crc_q;
endmodule // bmr_crc8

// ===== design/bmr_regs.sv
/*
  Register page of a battery identification and monitor slave: temperature,
  status, voltage, maker id, cycle counter, identity code with check value.
  Assumes a bus front end that decodes commands and byte addresses, and
  analog front ends that deliver results, temperature with a done strobe and voltage at the end of a count.
*/
`timescale 1ns/1ps
module bmr_regs #(
  parameter logic [15:0] MAKER_ID = 16'h0000, // arbitrary value
  parameter logic [7:0] FAMILY_CODE = 8'h00, // arbitrary value
  parameter logic [47:0] SERIAL_NUMBER = 48'h0000_0000_0001,
  parameter int VOLT_CYCLES = bmr_pkg::VOLT_CONV_CYCLES,
  parameter int NV_CYCLES = bmr_pkg::NV_COPY_MIN_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  // selection level and command strobes from the bus front end
  input wire logic rom_selected_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic cycle_inc_in,
  input wire logic cycle_clr_in,
  input wire logic nv_copy_start_in,
  input wire logic lock_set_in,
  input wire logic lock_clr_in,
  // analog front end handshakes and results
  input wire logic temp_start_in,
  input wire logic temp_done_in,
  input wire logic [12:0] temp_sample_in,
  input wire logic [9:0] volt_sample_in,
  // read port and check generator control
  input wire logic [7:0] rd_addr_in,
  input wire logic crc_clear_in,
  input wire logic crc_shift_in,
  input wire logic crc_bit_in,
  // read byte, check value, identity word and flags
  output logic [7:0] rd_data_out,
  output logic [7:0] crc_out,
  output logic [63:0] identity_out,
  output logic temp_busy_flag_out,
  output logic nonvolatile_busy_flag_out,
  output logic voltage_conv_busy_flag_out,
  output logic page_lock_out
);
  //////////////////////////////////////////////////////////////////////////
  // state
  // results and counter
  logic [15:0] temperature_result_q;
  logic [15:0] temperature_result_d;
  logic [15:0] battery_voltage_result_q;
  logic [15:0] battery_voltage_result_d;
  logic [15:0] charge_cycle_count_q;
  logic [15:0] charge_cycle_count_d;
  // flags
  logic temp_busy_flag_q;
  logic temp_busy_flag_d;
  logic nonvolatile_busy_flag_q;
  logic nonvolatile_busy_flag_d;
  logic voltage_conv_busy_flag_q;
  logic voltage_conv_busy_flag_d;
  logic lock_q;
  logic lock_d;
  // timers
  logic [23:0] volt_cnt_q;
  logic [23:0] volt_cnt_d;
  logic [23:0] nv_cnt_q;
  logic [23:0] nv_cnt_d;
  bmr_pkg::bmr_conv_type volt_st_q;
  bmr_pkg::bmr_conv_type volt_st_d;
  // read path and identity
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic [63:0] identity_q;
  logic [7:0] rom_crc;
  logic [7:0] crc_w;
  logic [7:0] status_lo;
  logic do_volt;

  //////////////////////////////////////////////////////////////////////////
  // identity code check byte
  // the check byte is worked out from the family and serial parameters,
  // so a mistyped constant can never leave the stored byte disagreeing
  // with the 56 bits that the master reads before it
  // bit 0 of the family code is the first bit fed and sent
  function automatic logic [7:0] crc_of56(input logic [55:0] data);
    logic [7:0] c;
    c = bmr_pkg::CRC_RESET;
    for (int i = 0; i < 56; i++) begin
      if (c[0] ^ data[i]) begin
        c = {1'b0, c[7:1]} ^ bmr_pkg::CRC_POLY_REFLECT;
      end else begin
        c = {1'b0, c[7:1]};
      end
    end
    return c;
  endfunction

  assign rom_crc = crc_of56({SERIAL_NUMBER, FAMILY_CODE});

  // serial check generator for page reads
  // it knows nothing of page bounds: the front end clears it at the
  // start of each page and shifts each sent bit through it
  bmr_crc8 u_crc (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(crc_clear_in),
    .shift_in(crc_shift_in),
    .bit_in(crc_bit_in),
    .crc_out(crc_w)
  );

  //////////////////////////////////////////////////////////////////////////
  // commands gated by rom selection
  // without a completed selection the command byte is ignored,
  // whatever its value
  assign do_volt = rom_selected_in && cmd_valid_in
                   && cmd_code_in == bmr_pkg::CMD_CONVERT_VOLT;

  // voltage conversion sequencer
  // a convert command that arrives while a conversion runs is dropped,
  // not queued: the master polls the busy flag before asking again;
  // the result register keeps the old reading until the last count,
  // so a read in mid-conversion never returns a half-loaded word
  always_comb begin
    volt_st_d = volt_st_q;
    volt_cnt_d = volt_cnt_q;
    voltage_conv_busy_flag_d = voltage_conv_busy_flag_q;
    battery_voltage_result_d = battery_voltage_result_q;
    case (volt_st_q)
      bmr_pkg::ST_IDLE: begin
        if (do_volt) begin
          volt_st_d = bmr_pkg::ST_BUSY;
          volt_cnt_d = 24'(VOLT_CYCLES - 1);
          voltage_conv_busy_flag_d = 1'b1;
        end
      end
      bmr_pkg::ST_BUSY: begin
        if (volt_cnt_q == 24'h00_0000) begin
          volt_st_d = bmr_pkg::ST_IDLE;
          voltage_conv_busy_flag_d = 1'b0;
          battery_voltage_result_d = {6'h00, volt_sample_in};
        end else begin
          volt_cnt_d = volt_cnt_q - 24'h00_0001;
        end
      end
      default: begin
        // an illegal state falls back to idle with busy low
        volt_st_d = bmr_pkg::ST_IDLE;
        voltage_conv_busy_flag_d = 1'b0;
      end
    endcase
  end

  // temperature, nonvolatile copy, lock and cycle counter next values
  // done is honoured only while busy, so a stray done strobe cannot
  // overwrite a valid reading; a start that meets done in the same
  // cycle loses, and the master must ask again once busy has cleared.
  // the copy timer runs from the shortest copy time; a slower memory
  // would need a longer count, which the parameter allows
  always_comb begin
    temp_busy_flag_d = temp_busy_flag_q;
    temperature_result_d = temperature_result_q;
    nonvolatile_busy_flag_d = nonvolatile_busy_flag_q;
    nv_cnt_d = nv_cnt_q;
    lock_d = lock_q;
    charge_cycle_count_d = charge_cycle_count_q;
    if (temp_busy_flag_q && temp_done_in) begin
      temp_busy_flag_d = 1'b0;
      temperature_result_d = {temp_sample_in, 3'b000};
    end else if (rom_selected_in && temp_start_in) begin
      temp_busy_flag_d = 1'b1;
    end
    // nv busy for the copy time
    if (nonvolatile_busy_flag_q) begin
      if (nv_cnt_q == 24'h00_0000) begin
        nonvolatile_busy_flag_d = 1'b0;
      end else begin
        nv_cnt_d = nv_cnt_q - 24'h00_0001;
      end
    end else if (rom_selected_in && nv_copy_start_in) begin
      nonvolatile_busy_flag_d = 1'b1;
      nv_cnt_d = 24'(NV_CYCLES - 1);
    end
    if (rom_selected_in && lock_set_in) begin
      lock_d = 1'b1;
    end else if (rom_selected_in && lock_clr_in) begin
      lock_d = 1'b0;
    end
    if (rom_selected_in && cycle_clr_in) begin
      charge_cycle_count_d = bmr_pkg::WORD_RESET;
    end else if (rom_selected_in && cycle_inc_in
                 && charge_cycle_count_q != bmr_pkg::CYCLE_MAX) begin
      charge_cycle_count_d = charge_cycle_count_q + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status low byte
  // bits 7 to 4 stay zero; every flag is read from its register, so a
  // status read shows the same value as the flag outputs
  always_comb begin
    status_lo = 8'h00;
    status_lo[bmr_pkg::STAT_TEMP_BIT] = temp_busy_flag_q;
    status_lo[bmr_pkg::STAT_NV_BIT] = nonvolatile_busy_flag_q;
    status_lo[bmr_pkg::STAT_LOCK_BIT] = lock_q;
    status_lo[bmr_pkg::STAT_VOLT_BIT] = voltage_conv_busy_flag_q;
  end

  // byte read mux; maker id is a constant
  // the byte is registered, so it appears one clock after its address;
  // addresses outside the page read as zero rather than as stale data
  always_comb begin
    case (rd_addr_in)
      bmr_pkg::TEMP_LO_ADDR: rd_data_d = temperature_result_q[7:0];
      bmr_pkg::TEMP_HI_ADDR: rd_data_d = temperature_result_q[15:8];
      bmr_pkg::STAT_LO_ADDR: rd_data_d = status_lo;
      bmr_pkg::STAT_HI_ADDR: rd_data_d = bmr_pkg::STAT_HI_VALUE;
      bmr_pkg::VOLT_LO_ADDR: rd_data_d = battery_voltage_result_q[7:0];
      bmr_pkg::VOLT_HI_ADDR: rd_data_d = battery_voltage_result_q[15:8];
      bmr_pkg::MAKER_LO_ADDR: rd_data_d = MAKER_ID[7:0];
      bmr_pkg::MAKER_HI_ADDR: rd_data_d = MAKER_ID[15:8];
      bmr_pkg::CYCLE_LO_ADDR: rd_data_d = charge_cycle_count_q[7:0];
      bmr_pkg::CYCLE_HI_ADDR: rd_data_d = charge_cycle_count_q[15:8];
      default: rd_data_d = bmr_pkg::UNMAPPED_VALUE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // registers
  // volatile state clears on reset; the identity word is reloaded from
  // constants on the first clock after reset is released
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      volt_st_q <= bmr_pkg::ST_IDLE;
      volt_cnt_q <= 24'h00_0000;
      nv_cnt_q <= 24'h00_0000;
      voltage_conv_busy_flag_q <= 1'b0;
      temp_busy_flag_q <= 1'b0;
      nonvolatile_busy_flag_q <= 1'b0;
      battery_voltage_result_q <= bmr_pkg::WORD_RESET;
      temperature_result_q <= bmr_pkg::WORD_RESET;
      rd_data_q <= 8'h00;
      identity_q <= 64'h0000_0000_0000_0000;
    end else begin
      volt_st_q <= volt_st_d;
      volt_cnt_q <= volt_cnt_d;
      nv_cnt_q <= nv_cnt_d;
      voltage_conv_busy_flag_q <= voltage_conv_busy_flag_d;
      temp_busy_flag_q <= temp_busy_flag_d;
      nonvolatile_busy_flag_q <= nonvolatile_busy_flag_d;
      battery_voltage_result_q <= battery_voltage_result_d;
      temperature_result_q <= temperature_result_d;
      rd_data_q <= rd_data_d;
      identity_q <= {rom_crc, SERIAL_NUMBER, FAMILY_CODE};
    end
  end

  // nonvolatile state survives reset
  // the lock bit and the counter model cells that keep their value
  // without supply, so reset leaves them alone; in simulation they stay
  // unknown until the front end issues a clear after power-up
  always_ff @(posedge clk_in) begin
    lock_q <= lock_d;
    charge_cycle_count_q <= charge_cycle_count_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a register
  // check byte always offered, never blocks
  // the generator keeps running whatever the master does with its value;
  // a mismatch is the master's business and stops nothing here
  assign crc_out = crc_w;
  assign rd_data_out = rd_data_q;
  assign identity_out = identity_q;
  assign temp_busy_flag_out = temp_busy_flag_q;
  assign nonvolatile_busy_flag_out = nonvolatile_busy_flag_q;
  assign voltage_conv_busy_flag_out = voltage_conv_busy_flag_q;
  assign page_lock_out = lock_q;
endmodule // bmr_regs

// ===== verif/bmr_regs_checker.sv
/* checker: timing relations of the register page ports.
   bound into bmr_regs with its shortened busy counts. */
`timescale 1ns/1ps
module bmr_regs_checker #(
  parameter int VOLT_CYCLES = 10,
  parameter int NV_CYCLES = 5
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic rom_selected_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic lock_set_in,
  input wire logic temp_start_in,
  input wire logic temp_done_in,
  input wire logic [7:0] rd_addr_in,
  input wire logic [7:0] rd_data_out,
  input wire logic temp_busy_flag_out,
  input wire logic nonvolatile_busy_flag_out,
  input wire logic voltage_conv_busy_flag_out,
  input wire logic page_lock_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  int volt_n_q, volt_n_d, nv_n_q, nv_n_d;
  logic idle;
  assign idle = !(temp_busy_flag_out | nonvolatile_busy_flag_out
    | voltage_conv_busy_flag_out);
  // count cycles the voltage and copy busy flags have been high
  always_comb begin
    volt_n_d = voltage_conv_busy_flag_out ? volt_n_q + 1 : 0;
    nv_n_d = nonvolatile_busy_flag_out ? nv_n_q + 1 : 0;
  end
  always_ff @(posedge clk_in) begin
    volt_n_q <= rst_in ? 0 : volt_n_d;
    nv_n_q <= rst_in ? 0 : nv_n_d;
  end
  ////////////////////////////////////////////////////////////////////
  a_volt_start: assert property (
    cmd_valid_in && rom_selected_in && cmd_code_in == 8'hb4
    && !voltage_conv_busy_flag_out |=> voltage_conv_busy_flag_out)
    else $error("voltage busy did not rise");
  // a reset cuts a conversion short, so a fall just after it is exempt
  a_volt_length: assert property (
    !$past(rst_in) && $fell(voltage_conv_busy_flag_out)
    |-> volt_n_q == VOLT_CYCLES)
    else $error("voltage busy length off");
  a_nv_length: assert property (
    !$past(rst_in) && $fell(nonvolatile_busy_flag_out)
    |-> nv_n_q == NV_CYCLES)
    else $error("copy busy length off");
  a_refused_unselected: assert property (
    !rom_selected_in && idle |=> idle)
    else $error("busy flag set while unselected");
  a_status_upper: assert property (
    rd_addr_in == 8'h63 |=> rd_data_out == 8'hff)
    else $error("upper status byte not ones");
  a_status_zero: assert property (
    rd_addr_in == 8'h62 |=> rd_data_out[7:4] == 4'h0)
    else $error("status top bits not zero");
  a_temp_fraction: assert property (
    rd_addr_in == 8'h60 |=> rd_data_out[2:0] == 3'h0)
    else $error("temperature low bits not zero");
  a_temp_done: assert property (
    temp_done_in && rom_selected_in && !temp_start_in
    |=> !temp_busy_flag_out)
    else $error("temperature busy stuck");
  a_lock_set: assert property (
    lock_set_in && rom_selected_in |=> page_lock_out)
    else $error("lock flag not set");
endmodule // bmr_regs_checker
bind bmr_regs bmr_regs_checker #(.VOLT_CYCLES(VOLT_CYCLES),
  .NV_CYCLES(NV_CYCLES)) i_bmr_regs_checker (.clk_in(clk_in),
  .rst_in(rst_in), .rom_selected_in(rom_selected_in),
  .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in),
  .lock_set_in(lock_set_in), .temp_start_in(temp_start_in),
  .temp_done_in(temp_done_in), .rd_addr_in(rd_addr_in),
  .rd_data_out(rd_data_out), .temp_busy_flag_out(temp_busy_flag_out),
  .nonvolatile_busy_flag_out(nonvolatile_busy_flag_out),
  .voltage_conv_busy_flag_out(voltage_conv_busy_flag_out),
  .page_lock_out(page_lock_out));

// ===== verif/bmr_master.sv
/* model of the bus master: feeds identity bits to the check generator.
   runs from the bench clock, called by the bench through feed. */
`timescale 1ns/1ps
module bmr_master (
  input wire logic clk_in,
  output logic clear_out,
  output logic shift_out,
  output logic bit_out
);
  initial begin
    clear_out = 1'b0;
    shift_out = 1'b0;
    bit_out = 1'b0;
  end
  task automatic feed(input logic [63:0] w, output logic [7:0] c);
    logic fb;
    c = 8'h00;
    @(posedge clk_in) clear_out <= 1'b1;
    @(posedge clk_in) clear_out <= 1'b0;
    for (int i = 0; i < 64; i++) begin
      shift_out <= 1'b1;
      bit_out <= w[i];
      fb = c[0] ^ w[i];
      if (i < 56) c = (c >> 1) ^ (fb ? 8'h8c : 8'h00);
      @(posedge clk_in);
    end
    shift_out <= 1'b0;
    bit_out <= ~w[63];
  endtask
endmodule // bmr_master

// ===== verif/testbench.sv
/* bench for the register page: table of results, then copy, lock,
   refusal, counter, check value and reset cases. */
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [12:0] t;
    logic [9:0] v;
    logic [15:0] te;
    logic [15:0] ve;
  } bmr_row_type;
  localparam logic [15:0] MAKER = 16'h5a3c; // arbitrary value
  localparam logic [7:0] FAMILY = 8'h47; // arbitrary value
  localparam logic [47:0] SERIAL = 48'h0123_4567_89ab;
  localparam bmr_row_type ROWS [4] = '{
    '{13'h0322, 10'h3e8, 16'h1910, 16'h03e8},
    '{13'h1cde, 10'h0f0, 16'he6f0, 16'h00f0},
    '{13'h1920, 10'h2d0, 16'hc900, 16'h02d0},
    '{13'h0000, 10'h001, 16'h0000, 16'h0001}};
  logic clk_in, rst_in, rom_sel, tb_f, nv_f, vb_f, lock_f, clr, sh, bt;
  logic [7:0] stb, code, addr, rd_data, crc, c;
  logic [12:0] temp_s;
  logic [9:0] volt_s;
  logic [63:0] ident;
  logic [15:0] v, last_v;
  int n_errors, total_checks;
  bmr_regs #(.MAKER_ID(MAKER), .FAMILY_CODE(FAMILY),
    .SERIAL_NUMBER(SERIAL), .VOLT_CYCLES(10), .NV_CYCLES(5)) i_bmr_regs (
    .clk_in(clk_in), .rst_in(rst_in), .rom_selected_in(rom_sel),
    .cmd_valid_in(stb[0]), .cmd_code_in(code), .cycle_inc_in(stb[1]),
    .cycle_clr_in(stb[2]), .nv_copy_start_in(stb[3]),
    .lock_set_in(stb[4]), .lock_clr_in(stb[5]), .temp_start_in(stb[6]),
    .temp_done_in(stb[7]), .temp_sample_in(temp_s),
    .volt_sample_in(volt_s), .rd_addr_in(addr), .crc_clear_in(clr),
    .crc_shift_in(sh), .crc_bit_in(bt), .rd_data_out(rd_data),
    .crc_out(crc), .identity_out(ident), .temp_busy_flag_out(tb_f),
    .nonvolatile_busy_flag_out(nv_f), .voltage_conv_busy_flag_out(vb_f),
    .page_lock_out(lock_f));
  bmr_master i_bmr_master (.clk_in(clk_in), .clear_out(clr),
    .shift_out(sh), .bit_out(bt));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task pulse(input logic [7:0] m);
    @(posedge clk_in) stb <= m;
    @(posedge clk_in) stb <= 8'h00;
  endtask
  // two-byte read, low byte at the lower address
  task rd16(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_in) addr <= a;
    @(posedge clk_in) addr <= a + 8'h01;
    @(negedge clk_in) d[7:0] = rd_data;
    @(posedge clk_in);
    @(negedge clk_in) d[15:8] = rd_data;
  endtask
  task wait_idle;
    for (int i = 0; i < 40 && {tb_f, nv_f, vb_f} !== 3'b000; i++)
      @(negedge clk_in);
    if ({tb_f, nv_f, vb_f} !== 3'b000) begin
      n_errors++;
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    {rst_in, rom_sel, stb, code, addr} = {2'b11, 16'h00b4, 8'h00};
    {temp_s, volt_s, last_v} = '0;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    pulse(8'h24);
    rd16(8'h62, v);
    chk("status", 16'hff00, v);
    rd16(8'h80, v);
    chk("maker", MAKER, v);
    rd16(8'h64, v);
    chk("unmapped", 16'h0000, v);
    foreach (ROWS[i]) begin
      @(posedge clk_in);
      temp_s <= ROWS[i].t;
      volt_s <= ROWS[i].v;
      pulse(8'h40);
      rd16(8'h62, v);
      chk("status", 16'hff01, v);
      pulse(8'h80);
      rd16(8'h60, v);
      chk("temp", ROWS[i].te, v);
      pulse(8'h01);
      rd16(8'h77, v);
      chk("volt held", last_v, v);
      rd16(8'h62, v);
      chk("status", 16'hff08, v);
      wait_idle();
      rd16(8'h77, v);
      chk("volt", ROWS[i].ve, v);
      last_v = ROWS[i].ve;
    end
    pulse(8'h08);
    rd16(8'h62, v);
    chk("copy status", 16'hff02, v);
    pulse(8'h08);
    @(negedge clk_in) chk("copy refused", 1'b0, nv_f);
    wait_idle();
    pulse(8'h10);
    rd16(8'h62, v);
    chk("lock", 16'hff04, v);
    pulse(8'h20);
    @(negedge clk_in) chk("lock pin", 1'b0, lock_f);
    @(posedge clk_in) rom_sel <= 1'b0;
    pulse(8'h4b);
    @(negedge clk_in) chk("refused", 3'b000, {tb_f, nv_f, vb_f});
    @(posedge clk_in) rom_sel <= 1'b1;
    pulse(8'h02);
    rd16(8'h82, v);
    chk("cycle", 16'h0001, v);
    @(posedge clk_in) stb <= 8'h02;
    repeat (65535) @(posedge clk_in);
    stb <= 8'h00;
    rd16(8'h82, v);
    chk("cycle max", 16'hffff, v);
    pulse(8'h06);
    rd16(8'h82, v);
    chk("cycle clear", 16'h0000, v);
    @(posedge clk_in) code <= 8'h00;
    pulse(8'h01);
    @(negedge clk_in) chk("other code", 1'b0, vb_f);
    @(posedge clk_in) code <= 8'hb4;
    i_bmr_master.feed(ident, c);
    chk("identity", {SERIAL, FAMILY}, ident[55:0]);
    chk("identity check", c, ident[63:56]);
    repeat (2) @(negedge clk_in);
    chk("check remainder", 8'h00, crc);
    pulse(8'h01);
    @(posedge clk_in) rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in) chk("busy after reset", 1'b0, vb_f);
    summarize();
  end
endmodule // testbench
